// [design/qspi_ctrl_pkg.sv]
package qspi_ctrl_pkg;

  // Register byte addresses
  localparam logic [31:0] MANUAL_BUS_COMMAND_ADDR = 32'h3400_0000;
  localparam logic [31:0] CONTROLLER_MODE_CONFIG_ADDR = 32'h3400_0004;
  localparam logic [31:0] CONTROLLER_STATUS_ADDR = 32'h3400_0014;
  localparam logic [31:0] ERASE_CONTROL_ADDR = 32'h3400_0024;

  // manual_bus_command fields
  localparam int SELECT_RELEASE_CMD_BIT = 4;
  localparam int SELECT_ASSERT_CMD_BIT = 3;
  localparam int FOUR_LINE_CMD_BIT = 2;
  localparam int TWO_LINE_CMD_BIT = 1;
  localparam int ONE_LINE_CMD_BIT = 0;

  // controller_mode_config fields
  localparam int FREE_RUNNING_SCK_BIT = 16;
  localparam int SELECT_EDGE_CHOICE_BIT = 15;
  localparam int MEMORY_IS_RAM_BIT = 14;
  localparam int LONG_ADDRESS_SELECT_BIT = 13;
  localparam int BURST_SPLIT_ENABLE_BIT = 12;
  localparam int AUTO_MODE_BIT = 0;

  // Status and erase fields
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_SELECT_BIT = 1;
  localparam int ERASE_TRIGGER_BIT = 0;

  // Serial sequence constants
  localparam logic [7:0] READ_OPCODE = 8'h0B;
  localparam logic [7:0] WRITE_OPCODE = 8'h02;
  localparam logic [2:0] SHORT_ADDR_LAST_BYTE = 3'h2;
  localparam logic [2:0] LONG_ADDR_LAST_BYTE = 3'h3;
  localparam logic [5:0] BYTE_LAST_BIT = 6'h07;
  localparam logic [5:0] DUMMY_LAST_CYCLE = 6'h07;
  localparam logic [5:0] ONE_LINE_LAST_CYCLE = 6'h1F;
  localparam logic [5:0] TWO_LINE_LAST_CYCLE = 6'h0F;
  localparam logic [5:0] FOUR_LINE_LAST_CYCLE = 6'h07;
  localparam logic [31:0] BEAT_BYTES = 32'h0000_0004;

  typedef enum logic [1:0] {
    LINES_ONE = 2'h0,
    LINES_TWO = 2'h1,
    LINES_FOUR = 2'h2
  } line_width_t;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'h0,
    SEQ_CMD = 3'h1,
    SEQ_ADDR = 3'h3,
    SEQ_DUMMY = 3'h2,
    SEQ_DATA = 3'h6,
    SEQ_CLOSE = 3'h4
  } seq_state_t;

  typedef struct packed {
    logic free_running_sck;
    logic select_edge_choice;
    logic memory_is_ram;
    logic long_address_select;
    logic burst_split_enable;
    logic auto_mode;
  } mode_cfg_t;

  localparam mode_cfg_t MODE_CFG_RESET = 6'h00;

  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [3:0] beats;
    logic write;
  } xfer_t;

endpackage : qspi_ctrl_pkg

// [design/qspi_bus_mode_control.sv]
// Summary of operation
// - Release command raises select in manual mode
// - Assert command lowers select in manual mode
// - Four-line command selects quad transfers
// - Two-line command selects dual transfers
// - One-line command restores single-line transfers
// - Edge choice zero: select on rise, clock idle
// - Edge choice one: select on falling edge
// - Edge one, no free clock: one pulse after select rises
// - Edge one, free clock: toggles while select inactive
// - Memory type picks flash or RAM
// - RAM disables erase; erase trigger ignored
// - RAM makes memory range writable
// - Address length picks 24 or 32 bits
// - Auto mode sends three or four address bytes
// - No split: one serial burst per burst
// - Split: full sequence per beat, select raised
`timescale 1ns/1ns
module qspi_bus_mode_control
  import qspi_ctrl_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  input wire logic i_xfer_req,
  input wire xfer_t i_xfer,
  output logic o_xfer_busy,
  output logic o_xfer_done,
  output logic o_xfer_refused,
  input wire logic i_erase_done,
  output logic o_erase_active,
  output logic o_erase_suspend_en,
  output logic o_mem_writable,
  input wire logic i_lnk_clk,
  output logic o_cs_b,
  output logic o_sck,
  output logic [3:0] o_io_out,
  output logic [3:0] o_io_oe
);

  // System clock domain
  mode_cfg_t cfg_reg;
  line_width_t width_reg;
  xfer_t xfer_reg;
  logic busy_reg, done_reg, refused_reg, erase_reg;
  logic [31:0] rdata_reg;
  logic as_tog_reg, rl_tog_reg, req_tog_reg;
  logic done_s1, done_s2, done_s3, busy_s1, busy_s2, cs_s1, cs_s2;
  logic wr_cmd, wr_mode, wr_erase;
  logic done_evt;

  assign wr_cmd = i_wr && (i_addr == MANUAL_BUS_COMMAND_ADDR);
  assign wr_mode = i_wr && (i_addr == CONTROLLER_MODE_CONFIG_ADDR);
  assign wr_erase = i_wr && (i_addr == ERASE_CONTROL_ADDR);
  assign done_evt = done_s2 ^ done_s3;

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_reg <= MODE_CFG_RESET;
    end else if (wr_mode) begin
      cfg_reg <= '{free_running_sck: i_wdata[FREE_RUNNING_SCK_BIT],
                   select_edge_choice: i_wdata[SELECT_EDGE_CHOICE_BIT],
                   memory_is_ram: i_wdata[MEMORY_IS_RAM_BIT],
                   long_address_select: i_wdata[LONG_ADDRESS_SELECT_BIT],
                   burst_split_enable: i_wdata[BURST_SPLIT_ENABLE_BIT],
                   auto_mode: i_wdata[AUTO_MODE_BIT]};
    end
  end

  // Select bits are strobes turned into toggles; the width command is stored in width_reg
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      width_reg <= LINES_ONE;
      as_tog_reg <= 1'b0;
      rl_tog_reg <= 1'b0;
    end else if (wr_cmd && !cfg_reg.auto_mode) begin
      if (i_wdata[ONE_LINE_CMD_BIT]) begin
        width_reg <= LINES_ONE;
      end else if (i_wdata[TWO_LINE_CMD_BIT]) begin
        width_reg <= LINES_TWO;
      end else if (i_wdata[FOUR_LINE_CMD_BIT]) begin
        width_reg <= LINES_FOUR;
      end
      if (i_wdata[SELECT_ASSERT_CMD_BIT]) begin
        as_tog_reg <= ~as_tog_reg;
      end
      if (i_wdata[SELECT_RELEASE_CMD_BIT]) begin
        rl_tog_reg <= ~rl_tog_reg;
      end
    end
  end

  // Erase trigger ignored with RAM attached; set wins over done
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      erase_reg <= 1'b0;
    end else if (wr_erase && i_wdata[ERASE_TRIGGER_BIT] && !cfg_reg.memory_is_ram) begin
      erase_reg <= 1'b1;
    end else if (i_erase_done || cfg_reg.memory_is_ram) begin
      erase_reg <= 1'b0;
    end
  end

  // Request is held in xfer_reg until done, so the link reads it stably
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
      refused_reg <= 1'b0;
      req_tog_reg <= 1'b0;
      xfer_reg <= '0;
    end else begin
      done_reg <= busy_reg && done_evt;
      refused_reg <= 1'b0;
      if (busy_reg && done_evt) begin
        busy_reg <= 1'b0;
      end
      if (i_xfer_req) begin
        if (busy_reg || !cfg_reg.auto_mode || (i_xfer.write && !cfg_reg.memory_is_ram)) begin
          refused_reg <= 1'b1;
        end else begin
          busy_reg <= 1'b1;
          xfer_reg <= i_xfer;
          req_tog_reg <= ~req_tog_reg;
        end
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      done_s3 <= 1'b0;
      busy_s1 <= 1'b0;
      busy_s2 <= 1'b0;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
    end else begin
      done_s1 <= lnk_done_tog;
      done_s2 <= done_s1;
      done_s3 <= done_s2;
      busy_s1 <= lnk_busy;
      busy_s2 <= busy_s1;
      cs_s1 <= cs_b_reg;
      cs_s2 <= cs_s1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= 32'h0000_0000;
      if (i_rd && i_addr == CONTROLLER_MODE_CONFIG_ADDR) begin
        rdata_reg[FREE_RUNNING_SCK_BIT] <= cfg_reg.free_running_sck;
        rdata_reg[SELECT_EDGE_CHOICE_BIT] <= cfg_reg.select_edge_choice;
        rdata_reg[MEMORY_IS_RAM_BIT] <= cfg_reg.memory_is_ram;
        rdata_reg[LONG_ADDRESS_SELECT_BIT] <= cfg_reg.long_address_select;
        rdata_reg[BURST_SPLIT_ENABLE_BIT] <= cfg_reg.burst_split_enable;
        rdata_reg[AUTO_MODE_BIT] <= cfg_reg.auto_mode;
      end else if (i_rd && i_addr == CONTROLLER_STATUS_ADDR) begin
        rdata_reg[STAT_BUSY_BIT] <= busy_reg | busy_s2;
        rdata_reg[STAT_SELECT_BIT] <= cs_s2;
      end else if (i_rd && i_addr == ERASE_CONTROL_ADDR) begin
        rdata_reg[ERASE_TRIGGER_BIT] <= erase_reg;
      end
    end
  end

  assign o_rdata = rdata_reg;
  assign o_xfer_busy = busy_reg;
  assign o_xfer_done = done_reg;
  assign o_xfer_refused = refused_reg;
  assign o_erase_active = erase_reg;
  assign o_erase_suspend_en = ~cfg_reg.memory_is_ram;
  assign o_mem_writable = cfg_reg.memory_is_ram;

  // Link clock domain
  mode_cfg_t cfg_s1, cfg;
  line_width_t width_s1, lw;
  logic as_s1, as_s2, as_s3, rl_s1, rl_s2, rl_s3, rq_s1, rq_s2, rq_s3;
  logic as_pend, rl_pend, rq_pend;
  logic sck_reg, cs_b_reg, pend_reg, lnk_done_tog, lnk_busy;
  logic sck_run, cs_slot, cyc_end, cs_b_next;
  seq_state_t st_reg, st_next;
  logic [5:0] bit_cnt, last_data;
  logic [2:0] byte_cnt, last_byte;
  logic [3:0] beat_cnt;
  logic [31:0] sh_reg, sh_n, seq_addr;
  logic [3:0] io_reg, oe_reg;

  // Config is quasi-static; two flops per level bit
  always_ff @(posedge i_lnk_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cfg_s1 <= MODE_CFG_RESET;
      cfg <= MODE_CFG_RESET;
      width_s1 <= LINES_ONE;
      lw <= LINES_ONE;
      {as_s1, as_s2, as_s3} <= 3'h0;
      {rl_s1, rl_s2, rl_s3} <= 3'h0;
      {rq_s1, rq_s2, rq_s3} <= 3'h0;
    end else begin
      cfg_s1 <= cfg_reg;
      cfg <= cfg_s1;
      width_s1 <= width_reg;
      lw <= width_s1;
      {as_s1, as_s2, as_s3} <= {as_tog_reg, as_s1, as_s2};
      {rl_s1, rl_s2, rl_s3} <= {rl_tog_reg, rl_s1, rl_s2};
      {rq_s1, rq_s2, rq_s3} <= {req_tog_reg, rq_s1, rq_s2};
    end
  end

  assign sck_run = ~cs_b_reg | (cfg.select_edge_choice & cfg.free_running_sck) | pend_reg;
  assign cs_slot = cfg.select_edge_choice ? (sck_reg | ~sck_run) : ~sck_reg;
  assign cyc_end = ~cs_b_reg & sck_reg;
  assign last_byte = cfg.long_address_select ? LONG_ADDR_LAST_BYTE : SHORT_ADDR_LAST_BYTE;
  assign last_data = (lw == LINES_FOUR) ? FOUR_LINE_LAST_CYCLE :
                     (lw == LINES_TWO) ? TWO_LINE_LAST_CYCLE : ONE_LINE_LAST_CYCLE;
  assign lnk_busy = (st_reg != SEQ_IDLE) | rq_pend;

  always_comb begin
    st_next = st_reg;
    cs_b_next = cs_b_reg;
    if (!cfg.auto_mode) begin
      if (rl_pend && cs_slot) begin
        cs_b_next = 1'b1;
      end else if (as_pend && cs_slot) begin
        cs_b_next = 1'b0;
      end
    end else begin
      case (st_reg)
        SEQ_IDLE: begin
          if (rq_pend && cs_slot) begin
            cs_b_next = 1'b0;
            st_next = SEQ_CMD;
          end
        end
        SEQ_CMD: begin
          if (cyc_end && bit_cnt == BYTE_LAST_BIT) begin
            st_next = SEQ_ADDR;
          end
        end
        SEQ_ADDR: begin
          if (cyc_end && bit_cnt[2:0] == 3'h7 && byte_cnt == last_byte) begin
            st_next = SEQ_DUMMY;
          end
        end
        SEQ_DUMMY: begin
          if (cyc_end && bit_cnt == DUMMY_LAST_CYCLE) begin
            st_next = SEQ_DATA;
          end
        end
        SEQ_DATA: begin
          if (cyc_end && bit_cnt == last_data &&
              (cfg.burst_split_enable || beat_cnt == xfer_reg.beats)) begin
            st_next = SEQ_CLOSE;
          end
        end
        SEQ_CLOSE: begin
          if (!cs_b_reg && cs_slot) begin
            cs_b_next = 1'b1;
          end else if (cs_b_reg && cs_slot) begin
            if (beat_cnt == xfer_reg.beats) begin
              st_next = SEQ_IDLE;
            end else begin
              cs_b_next = 1'b0;
              st_next = SEQ_CMD;
            end
          end
        end
        default: begin
          st_next = SEQ_IDLE;
          cs_b_next = 1'b1;
        end
      endcase
    end
  end

  // Clock and select pins
  always_ff @(posedge i_lnk_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sck_reg <= 1'b0;
      cs_b_reg <= 1'b1;
      pend_reg <= 1'b0;
      st_reg <= SEQ_IDLE;
    end else begin
      sck_reg <= sck_run ? ~sck_reg : 1'b0;
      cs_b_reg <= cs_b_next;
      st_reg <= st_next;
      if (cs_b_next && !cs_b_reg && cfg.select_edge_choice && !cfg.free_running_sck) begin
        pend_reg <= 1'b1;
      end else if (pend_reg && sck_reg) begin
        pend_reg <= 1'b0;
      end
    end
  end

  // Command pending flags; a fresh event beats its own clear
  always_ff @(posedge i_lnk_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      as_pend <= 1'b0;
      rl_pend <= 1'b0;
      rq_pend <= 1'b0;
      lnk_done_tog <= 1'b0;
    end else begin
      as_pend <= (as_s2 ^ as_s3) | (as_pend & ~(cs_slot & ~rl_pend) & ~cfg.auto_mode);
      rl_pend <= (rl_s2 ^ rl_s3) | (rl_pend & ~cs_slot & ~cfg.auto_mode);
      rq_pend <= (rq_s2 ^ rq_s3) | (rq_pend & ~(st_reg == SEQ_IDLE && st_next == SEQ_CMD));
      if (st_reg == SEQ_CLOSE && st_next == SEQ_IDLE) begin
        lnk_done_tog <= ~lnk_done_tog;
      end
    end
  end

  always_comb begin
    case (lw)
      LINES_FOUR: sh_n = {sh_reg[27:0], 4'h0};
      LINES_TWO: sh_n = {sh_reg[29:0], 2'h0};
      default: sh_n = {sh_reg[30:0], 1'b0};
    endcase
    if (st_reg != SEQ_DATA) begin
      sh_n = {sh_reg[30:0], 1'b0};
    end
  end

  // Shifter and counters
  always_ff @(posedge i_lnk_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sh_reg <= 32'h0000_0000;
      bit_cnt <= 6'h00;
      byte_cnt <= 3'h0;
      beat_cnt <= 4'h0;
      seq_addr <= 32'h0000_0000;
    end else if (st_reg == SEQ_IDLE && st_next == SEQ_CMD) begin
      seq_addr <= xfer_reg.addr;
      beat_cnt <= 4'h1;
      bit_cnt <= 6'h00;
      sh_reg <= {(xfer_reg.write ? WRITE_OPCODE : READ_OPCODE), 24'h00_0000};
    end else if (st_reg == SEQ_CLOSE && st_next == SEQ_CMD) begin
      seq_addr <= seq_addr + BEAT_BYTES;
      beat_cnt <= beat_cnt + 4'h1;
      bit_cnt <= 6'h00;
      sh_reg <= {(xfer_reg.write ? WRITE_OPCODE : READ_OPCODE), 24'h00_0000};
    end else if (cyc_end) begin
      bit_cnt <= bit_cnt + 6'h01;
      sh_reg <= sh_n;
      if (st_reg == SEQ_CMD && st_next == SEQ_ADDR) begin
        bit_cnt <= 6'h00;
        byte_cnt <= 3'h0;
        sh_reg <= cfg.long_address_select ? seq_addr : {seq_addr[23:0], 8'h00};
      end else if (st_reg == SEQ_ADDR && bit_cnt[2:0] == 3'h7) begin
        byte_cnt <= byte_cnt + 3'h1;
      end
      // Dummy phase counts from zero, not from the address bit count
      if (st_reg == SEQ_ADDR && st_next == SEQ_DUMMY) begin
        bit_cnt <= 6'h00;
      end
      if (st_reg == SEQ_DUMMY && st_next == SEQ_DATA) begin
        bit_cnt <= 6'h00;
        sh_reg <= xfer_reg.wdata;
      end
      if (st_reg == SEQ_DATA && bit_cnt == last_data && st_next == SEQ_DATA) begin
        bit_cnt <= 6'h00;
        beat_cnt <= beat_cnt + 4'h1;
        sh_reg <= xfer_reg.wdata;
      end
    end
  end

  always_ff @(posedge i_lnk_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      io_reg <= 4'h0;
      oe_reg <= 4'h0;
    end else if (st_reg == SEQ_DATA) begin
      io_reg <= (lw == LINES_FOUR) ? sh_reg[31:28] :
                (lw == LINES_TWO) ? {2'h0, sh_reg[31:30]} : {3'h0, sh_reg[31]};
      oe_reg <= !xfer_reg.write ? 4'h0 : (lw == LINES_FOUR) ? 4'hF :
                (lw == LINES_TWO) ? 4'h3 : 4'h1;
    end else if (st_reg == SEQ_CMD || st_reg == SEQ_ADDR || st_reg == SEQ_DUMMY) begin
      io_reg <= {3'h0, sh_reg[31]};
      oe_reg <= 4'h1;
    end else begin
      io_reg <= 4'h0;
      oe_reg <= 4'h0;
    end
  end

  assign o_cs_b = cs_b_reg;
  assign o_sck = sck_reg;
  assign o_io_out = io_reg;
  assign o_io_oe = oe_reg;

  // Checks, system domain
  a_quad_cmd: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    wr_cmd && !cfg_reg.auto_mode && i_wdata[2:0] == 3'h4 |=> width_reg == LINES_FOUR)
    else $error("quad command not applied");
  a_dual_cmd: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    wr_cmd && !cfg_reg.auto_mode && i_wdata[2:0] == 3'h2 |=> width_reg == LINES_TWO)
    else $error("dual command not applied");
  a_single_cmd: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    wr_cmd && !cfg_reg.auto_mode && i_wdata[0] |=> width_reg == LINES_ONE)
    else $error("single command not applied");
  a_zero_cmd_keeps: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    wr_cmd && i_wdata[4:0] == 5'h00 |=> $stable(width_reg) && $stable(as_tog_reg))
    else $error("zero command changed state");
  a_ram_no_erase: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    cfg_reg.memory_is_ram |=> !erase_reg)
    else $error("erase active with RAM");
  a_flash_write_refused: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    i_xfer_req && i_xfer.write && !cfg_reg.memory_is_ram |=> refused_reg && $stable(req_tog_reg))
    else $error("write to flash accepted");

  // Checks, link domain
  a_release_raises: assert property (@(posedge i_lnk_clk) disable iff (!i_rst_b)
    rl_pend && !cfg.auto_mode && $stable(cfg) |-> ##[1:3] cs_b_reg)
    else $error("release did not raise select");
  a_assert_lowers: assert property (@(posedge i_lnk_clk) disable iff (!i_rst_b)
    as_pend && !rl_pend && !cfg.auto_mode && $stable(cfg) |-> ##[1:3] !cs_b_reg)
    else $error("assert did not lower select");
  a_idle_sck_low: assert property (@(posedge i_lnk_clk) disable iff (!i_rst_b)
    !cfg.select_edge_choice && cs_b_reg && $past(cs_b_reg) && $stable(cfg) |-> !sck_reg)
    else $error("clock active with select high");
  a_cs_on_fall: assert property (@(posedge i_lnk_clk) disable iff (!i_rst_b)
    cfg.select_edge_choice && $stable(cfg) && $changed(cs_b_reg) |-> !sck_reg)
    else $error("select moved off the falling edge");
  a_one_pulse: assert property (@(posedge i_lnk_clk) disable iff (!i_rst_b)
    cfg.select_edge_choice && !cfg.free_running_sck && $stable(cfg) && $rose(cs_b_reg)
    |-> !sck_reg ##1 sck_reg ##1 !sck_reg)
    else $error("missing single clock pulse");
  a_free_toggle: assert property (@(posedge i_lnk_clk) disable iff (!i_rst_b)
    cfg.select_edge_choice && cfg.free_running_sck && $stable(cfg) && cs_b_reg && $past(cs_b_reg)
    |-> sck_reg != $past(sck_reg))
    else $error("free clock stopped");
  a_addr_bytes: assert property (@(posedge i_lnk_clk) disable iff (!i_rst_b)
    st_reg == SEQ_ADDR && st_next == SEQ_DUMMY |-> byte_cnt == last_byte)
    else $error("wrong address byte count");
  a_split_gap: assert property (@(posedge i_lnk_clk) disable iff (!i_rst_b)
    st_reg == SEQ_CLOSE && st_next == SEQ_CMD |-> cfg.burst_split_enable && cs_b_reg)
    else $error("beat sequence without split");

  c_manual_frame: cover property (@(posedge i_lnk_clk) disable iff (!i_rst_b)
    !cfg.auto_mode && $fell(cs_b_reg));
  c_split_burst: cover property (@(posedge i_lnk_clk) disable iff (!i_rst_b)
    st_reg == SEQ_CLOSE && st_next == SEQ_CMD);
  c_long_addr: cover property (@(posedge i_lnk_clk) disable iff (!i_rst_b)
    cfg.long_address_select && st_reg == SEQ_ADDR && st_next == SEQ_DUMMY);
  c_xfer_done: cover property (@(posedge i_mclk) disable iff (!i_rst_b) done_reg);

endmodule : qspi_bus_mode_control

// [tb/serial_mem_model.sv]
`timescale 1ns/1ns
module serial_mem_model (
  input wire logic i_cs_b,
  input wire logic i_sck,
  input wire logic [3:0] i_io,
  output int o_frames,
  output int o_last_bits,
  output int o_idle_rises,
  output logic [7:0] o_last_op
);
  int bits = 0;
  logic [7:0] op = 8'h00;
  initial begin
    o_frames = 0;
    o_last_bits = 0;
    o_idle_rises = 0;
    o_last_op = 8'h00;
  end
  // Pure listener: the memory never drives back in these tests
  // Select and data move on the same edge as the clock; look once they settle
  always @(posedge i_sck) begin
    #1;
    if (i_cs_b) begin
      o_idle_rises <= o_idle_rises + 1;
    end else begin
      if (bits < 8) op <= {op[6:0], i_io[0]};
      bits <= bits + 1;
    end
  end
  always @(posedge i_cs_b) begin
    o_frames <= o_frames + 1;
    o_last_bits <= bits;
    o_last_op <= op;
    bits <= 0;
  end
endmodule : serial_mem_model

// [tb/qspi_bus_mode_control_bench.sv]
`timescale 1ns/1ns
module qspi_bus_mode_control_bench;
  import qspi_ctrl_pkg::*;
  logic i_mclk = 0, i_rst_b = 0, i_wr = 0, i_rd = 0, i_xfer_req = 0, i_erase_done = 0;
  logic i_lnk_clk = 0;
  logic [31:0] i_addr = 32'h0000_0000, i_wdata = 32'h0000_0000, o_rdata, d;
  xfer_t i_xfer = '0;
  logic o_xfer_busy, o_xfer_done, o_xfer_refused, o_erase_active, o_erase_suspend_en;
  logic o_mem_writable, o_cs_b, o_sck;
  logic [3:0] o_io_out, o_io_oe;
  logic [31:0] seed = 32'h0000_3E19;
  logic [7:0] last_op;
  int num_errors = 0, num_checks = 0, cyc = 0, frames, last_bits, idle, i0;
  qspi_bus_mode_control DUT (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_xfer_req(i_xfer_req),
    .i_xfer(i_xfer), .o_xfer_busy(o_xfer_busy), .o_xfer_done(o_xfer_done),
    .o_xfer_refused(o_xfer_refused), .i_erase_done(i_erase_done),
    .o_erase_active(o_erase_active), .o_erase_suspend_en(o_erase_suspend_en),
    .o_mem_writable(o_mem_writable), .i_lnk_clk(i_lnk_clk), .o_cs_b(o_cs_b), .o_sck(o_sck),
    .o_io_out(o_io_out), .o_io_oe(o_io_oe));
  serial_mem_model mem (.i_cs_b(o_cs_b), .i_sck(o_sck), .i_io(o_io_out), .o_frames(frames),
    .o_last_bits(last_bits), .o_idle_rises(idle), .o_last_op(last_op));
  initial forever #20 i_mclk = ~i_mclk;
  initial begin
    #7;
    forever #24 i_lnk_clk = ~i_lnk_clk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic int exp_bits(input logic lng, input int beats);
    return 16 + (lng ? 32 : 24) + 32 * beats;
  endfunction : exp_bits
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [31:0] a, input logic [31:0] v);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    @(posedge i_mclk);
  endtask : wr
  task automatic rd(input logic [31:0] a);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 d = o_rdata;
    @(posedge i_mclk);
  endtask : rd
  task automatic wait_cs(input logic v);
    for (int n = 0; n < 60 && o_cs_b !== v; n++) @(posedge i_mclk);
    chk({31'h0, o_cs_b}, {31'h0, v});
  endtask : wait_cs
  task automatic xfer(input logic [31:0] mode, input logic [3:0] nb, input logic w);
    int f0;
    f0 = frames;
    wr(CONTROLLER_MODE_CONFIG_ADDR, mode);
    i_xfer <= '{addr: rnd(), wdata: rnd(), beats: nb, write: w};
    i_xfer_req <= 1'b1;
    @(posedge i_mclk);
    i_xfer_req <= 1'b0;
    for (int n = 0; n < 4000 && o_xfer_done !== 1'b1; n++) @(posedge i_mclk) #1;
    @(posedge i_mclk);
    chk(32'(frames - f0), mode[BURST_SPLIT_ENABLE_BIT] ? 32'(nb) : 32'h1);
    chk(32'(last_bits), 32'(exp_bits(mode[LONG_ADDRESS_SELECT_BIT], mode[12] ? 1 : nb)));
    chk({24'h0, last_op}, {24'h0, w ? WRITE_OPCODE : READ_OPCODE});
  endtask : xfer
  task automatic tally_and_finish();
    if (num_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      tally_and_finish();
    end
  end
  initial begin
    // Three cycles so the slower link domain sees two edges in reset
    repeat (3) @(posedge i_mclk);
    i_rst_b <= 1'b1;
    @(posedge i_mclk);
    rd(CONTROLLER_MODE_CONFIG_ADDR);
    chk(d, 32'h0000_0000);
    rd(MANUAL_BUS_COMMAND_ADDR);
    chk(d, 32'h0000_0000);
    rd(32'h3400_0008);
    chk(d, 32'h0000_0000);
    for (int k = 0; k < 4; k++) begin
      i0 = rnd() & 32'h0001_F000;
      wr(CONTROLLER_MODE_CONFIG_ADDR, i0);
      rd(CONTROLLER_MODE_CONFIG_ADDR);
      chk(d, i0);
      chk({31'h0, o_mem_writable}, {31'h0, i0[14]});
      chk({31'h0, o_erase_suspend_en}, {31'h0, ~i0[14]});
    end
    wr(CONTROLLER_MODE_CONFIG_ADDR, 32'h0000_0000);
    wr(ERASE_CONTROL_ADDR, 32'h0000_0001);
    chk({31'h0, o_erase_active}, 32'h1);
    i_erase_done <= 1'b1;
    @(posedge i_mclk);
    i_erase_done <= 1'b0;
    @(posedge i_mclk) #1;
    chk({31'h0, o_erase_active}, 32'h0);
    wr(CONTROLLER_MODE_CONFIG_ADDR, 32'h0000_4000);
    wr(ERASE_CONTROL_ADDR, 32'h0000_0001);
    chk({31'h0, o_erase_active}, 32'h0);
    wr(CONTROLLER_MODE_CONFIG_ADDR, 32'h0000_0000);
    wr(MANUAL_BUS_COMMAND_ADDR, 32'h0000_0008);
    wait_cs(1'b0);
    for (int b = 2; b >= 0; b--) wr(MANUAL_BUS_COMMAND_ADDR, 32'h1 << b);
    wr(MANUAL_BUS_COMMAND_ADDR, 32'h0000_0000);
    repeat (10) @(posedge i_mclk);
    chk({31'h0, o_cs_b}, 32'h0);
    wr(MANUAL_BUS_COMMAND_ADDR, 32'h0000_0010);
    wait_cs(1'b1);
    repeat (20) @(posedge i_mclk);
    i0 = idle;
    repeat (40) @(posedge i_mclk);
    chk(32'(idle - i0), 32'h0);
    wr(CONTROLLER_MODE_CONFIG_ADDR, 32'h0001_8000);
    repeat (20) @(posedge i_mclk);
    i0 = idle;
    repeat (40) @(posedge i_mclk);
    chk({31'h0, idle - i0 > 5}, 32'h1);
    wr(CONTROLLER_MODE_CONFIG_ADDR, 32'h0000_8000);
    wr(MANUAL_BUS_COMMAND_ADDR, 32'h0000_0008);
    wait_cs(1'b0);
    i0 = idle;
    wr(MANUAL_BUS_COMMAND_ADDR, 32'h0000_0010);
    wait_cs(1'b1);
    repeat (40) @(posedge i_mclk);
    chk(32'(idle - i0), 32'h1);
    xfer(32'h0000_4001, 4'h2, 1'b0);
    xfer(32'h0000_6001, 4'h1, 1'b0);
    xfer(32'h0000_5001, 4'h3, 1'b1);
    wr(CONTROLLER_MODE_CONFIG_ADDR, 32'h0000_0001);
    i_xfer <= '{addr: rnd(), wdata: rnd(), beats: 4'h1, write: 1'b1};
    i_xfer_req <= 1'b1;
    @(posedge i_mclk);
    i_xfer_req <= 1'b0;
    #1 chk({31'h0, o_xfer_refused}, 32'h1);
    repeat (4) @(posedge i_mclk);
    tally_and_finish();
  end
endmodule : qspi_bus_mode_control_bench
